// [logic/seq_pkg.sv]
// package of constants and carrier types for the converter channel sequencer
package seq_pkg;
    // ***********************
    // widths and counts
    // ***********************
    localparam int        NUM_CH      = 8;       // channels 0..7
    localparam int        SEL_W       = 4;       // input select width, 0 = not connected
    localparam logic [3:0] SEL_NC     = 4'h0;    // select value that leaves the input open
    localparam int        RAW_W       = 12;      // converter core result width
    localparam int        RES_W       = 16;      // stored result halfword
    localparam int        WORD_W      = 32;      // memory word
    localparam int        ADDR_W      = 32;      // memory address width
    localparam int        CNT_W       = 15;      // buffer capacity width
    localparam int        OS_W        = 4;       // accumulation exponent width
    localparam int        OS_MAX      = 8;       // largest exponent honoured
    localparam int        ACC_W       = RAW_W + OS_MAX + 1; // accumulator width
    localparam int        ACQUISITION_TIME_W      = 3;       // acquisition time code width
    localparam int        RATE_W      = 11;      // rate compare field width
    localparam int        FIFO_DEPTH  = 8;       // words buffered before memory
    // ***********************
    // acquisition times in microseconds, by code
    // ***********************
    localparam int        CLK_MHZ     = 100;     // clock rate
    localparam int        ACQUISITION_TIME_US [0:5] = '{3, 5, 10, 15, 20, 40};
    localparam int        ACQ_CNT_W   = 13;      // holds 40 us of cycles
    // channel configuration fields
    typedef struct packed {
        logic              diff;      // differential mode
        logic              burst;     // burst oversampling
        logic [ACQUISITION_TIME_W-1:0] acquisition_time;      // acquisition time code
    } chan_cfg_s;
    // converter core request
    typedef struct packed {
        logic [SEL_W-1:0]  psel;      // positive source
        logic [SEL_W-1:0]  nsel;      // negative source, 0 = ground
        logic              diff;      // differential conversion
    } conv_req_s;
    // acquisition time code to cycles, codes above 5 take the longest time
    function automatic logic [ACQ_CNT_W-1:0] acq_cycles(input logic [ACQUISITION_TIME_W-1:0] code);
        int us;
        us = (code > 3'h5) ? ACQUISITION_TIME_US[5] : ACQUISITION_TIME_US[code];
        return ACQ_CNT_W'(us * CLK_MHZ);
    endfunction
endpackage

// [logic/seq_fifo.sv]
// small word FIFO between the sequencer and the memory port
`timescale 1ns/1ps
`default_nettype none
module seq_fifo #(
    parameter int WIDTH = 32,                   // word width
    parameter int DEPTH = 8                     // words held
) (
    input  wire logic             clk,          // clock
    input  wire logic             rst,          // synchronous reset
    input  wire logic             in_valid,     // write request
    output logic                  in_ready,     // space left
    input  wire logic [WIDTH-1:0] in_data,      // write word
    output logic                  out_valid,    // word available
    input  wire logic             out_ready,    // reader takes word
    output logic [WIDTH-1:0]      out_data,     // read word, read straight from storage at the read index
    input  wire logic             flush         // drop contents
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];          // storage
    logic [AW-1:0]    wr_reg;                   // write index
    logic [AW-1:0]    rd_reg;                   // read index
    logic [AW:0]      cnt_reg;                  // stored words
    wire  do_wr = in_valid && in_ready;         // word accepted
    wire  do_rd = out_valid && out_ready;       // word leaves
    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rd_reg];
    // storage writes carry no reset, so they map onto plain ram
    always_ff @(posedge clk)
    begin
        if (do_wr)
            mem[wr_reg] <= in_data;
    end
    // pointers and fill count
    always_ff @(posedge clk)
    begin
        if (rst || flush)
        begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (do_wr) wr_reg <= AW'(wr_reg + 1'b1);
            if (do_rd) rd_reg <= AW'(rd_reg + 1'b1);
            cnt_reg <= (AW+1)'(cnt_reg + do_wr - do_rd);
        end
    end
endmodule // seq_fifo
`default_nettype wire

// [logic/adc_channel_sequencer.sv]
// converter channel sequencer: mode selection, oversampling, result packing
`timescale 1ns/1ps
`default_nettype none
module adc_channel_sequencer
    import seq_pkg::*;
(
    input  wire logic                    clk,              // 100 MHz clock
    input  wire logic                    rst,              // synchronous reset, active high
    // ***********************
    // tasks and configuration
    // ***********************
    input  wire logic                    start_task,       // arm buffer, one-cycle pulse
    input  wire logic                    sample_task,      // sample, one-cycle pulse
    input  wire logic                    stop_task,        // stop, one-cycle pulse
    input  wire logic [NUM_CH*SEL_W-1:0] positive_input_select, // per channel positive source
    input  wire logic [NUM_CH*SEL_W-1:0] negative_input_select, // per channel negative source
    input  wire chan_cfg_s [NUM_CH-1:0]  channel_configuration, // per channel settings
    input  wire logic [OS_W-1:0]         accumulation_exponent, // oversampling exponent
    input  wire logic                    local_rate_timer, // 1 = timer mode
    input  wire logic [RATE_W-1:0]       rate_compare_field, // timer period in cycles
    input  wire logic [ADDR_W-1:0]       buffer_pointer,   // buffer base address
    input  wire logic [CNT_W-1:0]        buffer_capacity,  // results in buffer
    // ***********************
    // converter core
    // ***********************
    output var conv_req_s                conv_req,         // selected inputs
    output logic                         conv_acquire,     // sampling capacitor connected
    output logic                         conv_start,       // start conversion, pulse
    input  wire logic                    conv_done,        // conversion finished, pulse
    input  wire logic [RAW_W-1:0]        conv_result,      // signed core result
    // ***********************
    // memory write port
    // ***********************
    output logic                         mem_valid,        // write request
    input  wire logic                    mem_ready,        // write taken
    output logic [ADDR_W-1:0]            mem_addr,         // word address
    output logic [WORD_W-1:0]            mem_data,         // word data
    output logic [3:0]                   mem_strb,         // byte enables
    // ***********************
    // events and status
    // ***********************
    output logic                         started_event,    // start taken, pulse
    output logic                         done_event,       // conversion complete, pulse
    output logic                         result_ready_event, // result ready, pulse
    output logic                         end_event,        // buffer full, pulse
    output logic                         stopped_event,    // stopped, pulse
    output logic                         busy,             // sequence running
    output logic [CNT_W-1:0]             result_amount     // results sent to memory
);
    // ***********************
    // state
    // ***********************
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,                      // waiting for a sample
        ST_ACQ  = 4'b0010,                      // capacitor connected
        ST_CONV = 4'b0100,                      // converter running
        ST_WAIT = 4'b1000                       // timer wait between samples
    } state_e;
    state_e               state_reg, state_next;  // sequencer state
    logic [2:0]           ch_reg;                 // current channel
    logic [ACQ_CNT_W-1:0] tmr_reg;                // acquisition / rate timer
    logic [ACC_W-1:0]     acc_reg [NUM_CH];       // per channel accumulator
    logic [OS_MAX:0]      os_cnt_reg [NUM_CH];    // per channel conversions gathered
    logic                 armed_reg;              // buffer open since start
    logic                 half_reg;               // low half held
    logic [RES_W-1:0]     low_reg;                // held low half
    logic [CNT_W-1:0]     queued_reg;             // results packed so far
    logic [ADDR_W-1:0]    waddr_reg;              // next word address
    logic                 timer_run_reg;          // rate timer active
    // ***********************
    // decoding
    // ***********************
    wire  [NUM_CH-1:0] ch_en;                        // enabled channels
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_en
            assign ch_en[g] = positive_input_select[g*SEL_W +: SEL_W] != SEL_NC;
        end
    endgenerate
    // next enabled channel at or above a given index, 0 flag when none
    function automatic logic [3:0] next_ch(input logic [NUM_CH-1:0] en, input int from);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NUM_CH-1; i >= 0; i--)
            if (en[i] && i >= from) r = {1'b1, 3'(i)};
        return r;
    endfunction
    wire  [3:0] first_ch    = next_ch(ch_en, 0);                 // lowest enabled
    wire  [3:0] after_ch    = next_ch(ch_en, int'(ch_reg) + 1);
    wire        any_en      = first_ch[3];
    wire        scan        = $countones(ch_en) > 1;
    wire  [OS_W-1:0] os_n   = (accumulation_exponent > OS_W'(OS_MAX)) ? OS_W'(OS_MAX)
                                                                      : accumulation_exponent;
    wire  [OS_MAX:0] os_total = (OS_MAX+1)'(1) << os_n;
    wire chan_cfg_s cur_cfg = channel_configuration[ch_reg];     // follows the current channel
    wire        cur_burst   = cur_cfg.burst && (os_n != '0);
    wire  [ACC_W-1:0] acc_sum = acc_reg[ch_reg] + ACC_W'($signed(conv_result));
    wire        os_full     = (os_cnt_reg[ch_reg] + 1'b1) == os_total;
    // averaged result keeps single-sample scale, then sign extended
    wire  [ACC_W-1:0] avg   = ACC_W'($signed(acc_sum) >>> os_n);
    wire  [RES_W-1:0] res16 = RES_W'($signed(avg[RAW_W-1:0]));
    wire        fifo_ready;                                      // space for a word
    wire        fifo_valid;                                      // word waiting
    wire        take_result = (state_reg == ST_CONV) && conv_done && os_full;
    wire        room        = armed_reg && (queued_reg < buffer_capacity);
    wire        last_res    = (queued_reg + 1'b1) == buffer_capacity;
    wire        push        = take_result && room && (half_reg || last_res);
    // sample tasks are ignored while the word buffer is full
    wire        can_sample  = any_en && armed_reg && fifo_ready;
    // ***********************
    // sequencer next state
    // ***********************
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (sample_task && can_sample)
                    state_next = ST_ACQ;
            ST_ACQ:
                if (tmr_reg == '0)
                    state_next = ST_CONV;
            ST_CONV:
                if (conv_done)
                begin
                    if (cur_burst && !os_full)
                        state_next = ST_ACQ;
                    else if (scan && after_ch[3])
                        state_next = ST_ACQ;
                    else if (timer_run_reg && !scan)
                        state_next = ST_WAIT;
                    else
                        state_next = ST_IDLE;
                end
            ST_WAIT:
                if (tmr_reg == '0)
                    state_next = fifo_ready ? ST_ACQ : ST_WAIT;
            default:
                state_next = ST_IDLE;
        endcase
        if (stop_task || end_event)
            state_next = ST_IDLE;
    end
    // ***********************
    // sequencer registers
    // ***********************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg     <= ST_IDLE;
            ch_reg        <= 3'h0;
            tmr_reg       <= '0;
            timer_run_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            // channel loads on entry to acquisition from idle or on a scan step, timer loads on entry to acquisition or wait
            if (state_reg == ST_IDLE && state_next == ST_ACQ)
            begin
                ch_reg        <= first_ch[2:0];
                tmr_reg       <= acq_cycles(channel_configuration[first_ch[2:0]].acquisition_time);
                timer_run_reg <= local_rate_timer;
            end
            else if (state_reg == ST_CONV && state_next == ST_ACQ)
            begin
                if (!(cur_burst && !os_full))
                    ch_reg <= after_ch[2:0];
                tmr_reg <= acq_cycles(channel_configuration[
                           (cur_burst && !os_full) ? ch_reg : after_ch[2:0]].acquisition_time);
            end
            else if (state_next == ST_WAIT && state_reg == ST_CONV)
                tmr_reg <= ACQ_CNT_W'(rate_compare_field);
            else if (state_reg == ST_WAIT && state_next == ST_ACQ)
                tmr_reg <= acq_cycles(cur_cfg.acquisition_time);
            else if (tmr_reg != '0)
                tmr_reg <= ACQ_CNT_W'(tmr_reg - 1'b1);
            if (stop_task)
                timer_run_reg <= 1'b0;
        end
    end
    // ***********************
    // accumulators
    // ***********************
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (rst || start_task || stop_task)
            begin
                acc_reg[i]    <= '0;
                os_cnt_reg[i] <= '0;
            end
            else if (state_reg == ST_CONV && conv_done && ch_reg == 3'(i))
            begin
                acc_reg[i]    <= os_full ? '0 : acc_sum;
                os_cnt_reg[i] <= os_full ? '0 : (OS_MAX+1)'(os_cnt_reg[i] + 1'b1);
            end
        end
    end
    // ***********************
    // packing and events
    // ***********************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            armed_reg          <= 1'b0;
            half_reg           <= 1'b0;
            low_reg            <= '0;
            queued_reg         <= '0;
            waddr_reg          <= '0;
            started_event      <= 1'b0;
            done_event         <= 1'b0;
            result_ready_event <= 1'b0;
            end_event          <= 1'b0;
            stopped_event      <= 1'b0;
        end
        else
        begin
            started_event      <= start_task;
            stopped_event      <= stop_task;
            done_event         <= (state_reg == ST_CONV) && conv_done;
            result_ready_event <= take_result;
            end_event          <= take_result && room && last_res;
            if (start_task)
            begin
                armed_reg  <= 1'b1;
                half_reg   <= 1'b0;
                queued_reg <= '0;
                waddr_reg  <= buffer_pointer;
            end
            else if (stop_task || end_event)
                armed_reg <= 1'b0;
            else if (take_result && room)
            begin
                queued_reg <= CNT_W'(queued_reg + 1'b1);
                half_reg   <= !half_reg && !last_res;
                low_reg    <= res16;
                if (push)
                    waddr_reg <= ADDR_W'(waddr_reg + 32'h0000_0004);
            end
        end
    end
    // low half first, odd last result alone in low half
    wire [WORD_W-1:0] word_in = half_reg ? {res16, low_reg}
                                         : {{RES_W{1'b0}}, res16};
    wire [3:0]        strb_in = half_reg ? 4'hF : 4'h3;
    wire [WORD_W+ADDR_W+3:0] f_out;
    seq_fifo #(
        .WIDTH (WORD_W + ADDR_W + 4),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   ({strb_in, waddr_reg, word_in}),
        .out_valid (fifo_valid),
        .out_ready (!mem_valid || mem_ready),
        .out_data  (f_out),
        .flush     (1'b0)
    );
    // ***********************
    // registered outputs
    // ***********************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mem_valid     <= 1'b0;
            mem_addr      <= '0;
            mem_data      <= '0;
            mem_strb      <= 4'h0;
            conv_req      <= '0;
            conv_acquire  <= 1'b0;
            conv_start    <= 1'b0;
            busy          <= 1'b0;
            result_amount <= '0;
        end
        else
        begin
            if (!mem_valid || mem_ready)
            begin
                mem_valid <= fifo_valid;
                {mem_strb, mem_addr, mem_data} <= f_out;
            end
            if (start_task)
                result_amount <= '0;
            else if (mem_valid && mem_ready)
                result_amount <= CNT_W'(result_amount + (mem_strb[3] ? 2'd2 : 2'd1));
            conv_req.psel <= positive_input_select[ch_reg*SEL_W +: SEL_W];
            conv_req.diff <= cur_cfg.diff;
            conv_req.nsel <= cur_cfg.diff ? negative_input_select[ch_reg*SEL_W +: SEL_W]
                                          : SEL_NC;
            conv_acquire  <= (state_reg == ST_ACQ);
            conv_start    <= (state_reg == ST_ACQ) && (tmr_reg == '0);
            busy          <= (state_next != ST_IDLE);
        end
    end
endmodule // adc_channel_sequencer
`default_nettype wire

// [verif/adc_channel_sequencer_props.sv]
// port-level assertions for the converter channel sequencer
`timescale 1ns/1ps
`default_nettype none
module seq_props
    import seq_pkg::*;
(
    input wire logic            clk,                   // clock
    input wire logic            rst,                   // synchronous reset
    input wire logic            stop_task,             // stop pulse
    input wire logic [OS_W-1:0] accumulation_exponent, // oversampling exponent
    input wire conv_req_s       conv_req,              // selected inputs
    input wire logic            conv_acquire,          // capacitor connected
    input wire logic            conv_start,            // conversion start
    input wire logic            conv_done,             // core finished
    input wire logic            mem_valid,             // write request
    input wire logic            mem_ready,             // write taken
    input wire logic [31:0]     mem_addr,              // word address
    input wire logic [31:0]     mem_data,              // word data
    input wire logic            done_event,            // conversion complete
    input wire logic            result_ready_event,    // result ready
    input wire logic            stopped_event          // stopped
);
    // ***********************
    // properties
    // ***********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // shortest code is 300 cycles, so eight is a safe floor
    sequence s_acq_hold; conv_acquire [*8]; endsequence
    sequence s_word_held; mem_valid && $stable(mem_addr) && $stable(mem_data); endsequence
    property p_acq; $rose(conv_acquire) |-> s_acq_hold; endproperty
    property p_start; conv_start |-> $past(conv_acquire); endproperty
    property p_done; done_event |-> $past(conv_done); endproperty
    property p_rr0; done_event && accumulation_exponent == 4'h0 |-> result_ready_event; endproperty
    property p_rr; result_ready_event |-> done_event; endproperty
    property p_gnd; conv_acquire && !conv_req.diff |-> conv_req.nsel == SEL_NC; endproperty
    property p_en; conv_acquire |-> conv_req.psel != SEL_NC; endproperty
    property p_hold; mem_valid && !mem_ready |=> s_word_held; endproperty
    property p_stop; stop_task |=> stopped_event; endproperty
    a_acq: assert property (p_acq) else $error("acquisition cut short");
    a_start: assert property (p_start) else $error("start without acquisition");
    a_done: assert property (p_done) else $error("done without core finish");
    a_rr0: assert property (p_rr0) else $error("result ready missing");
    a_rr: assert property (p_rr) else $error("result ready alone");
    a_gnd: assert property (p_gnd) else $error("negative input not grounded");
    a_en: assert property (p_en) else $error("disabled channel converted");
    a_hold: assert property (p_hold) else $error("write word changed");
    a_stop: assert property (p_stop) else $error("stopped missing");
endmodule // seq_props
`default_nettype wire

// [verif/conv_mem_model.sv]
// converter core and memory sink facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module conv_mem_model
    import seq_pkg::*;
(
    input wire logic              clk,         // clock
    input wire conv_req_s         conv_req,    // selected inputs
    input wire logic              conv_start,  // start pulse
    output logic                  conv_done = 1'b0, // finished pulse
    output logic [RAW_W-1:0]      conv_result, // core result
    input wire logic              mem_valid,   // write request
    output logic                  mem_ready = 1'b0, // write taken
    input wire logic [ADDR_W-1:0] mem_addr,    // word address
    input wire logic [WORD_W-1:0] mem_data,    // word data
    input wire logic [3:0]        mem_strb     // byte enables
);
    logic [2:0]  cnt_reg = 3'h0;   // conversion cycles left
    logic [7:0]  stall_reg = 8'hA5; // ready pattern, stalls the writer
    logic [67:0] words[$];         // accepted writes {addr,strb,data}
    wire  [RAW_W-1:0] tag = {conv_req.psel, conv_req.nsel, 4'hA}; // tells selects apart
    // outside a conversion the result is inverted
    assign conv_result = (cnt_reg != 3'h0 || conv_done) ? tag : ~tag;
    // ***********************
    // core timing and ready stalls
    // ***********************
    always @(negedge clk)
    begin
        conv_done <= (cnt_reg == 3'h1);
        cnt_reg <= conv_start ? 3'h4 : cnt_reg - (cnt_reg != 3'h0);
        stall_reg <= {stall_reg[6:0], stall_reg[7] ^ stall_reg[5]};
        mem_ready <= stall_reg[0];
    end
    // collect every word the sequencer hands over
    always @(posedge clk)
        if (mem_valid && mem_ready)
            words.push_back({mem_addr, mem_strb, mem_data});
endmodule // conv_mem_model
`default_nettype wire

// [verif/test_adc_channel_sequencer.sv]
// self-checking bench for the converter channel sequencer
`timescale 1ns/1ps
`default_nettype none
module test_adc_channel_sequencer
    import seq_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, start_task = 1'b0, sample_task = 1'b0, stop_task = 1'b0, local_rate_timer = 1'b0;
    logic [31:0] positive_input_select = '0, negative_input_select = '0, buffer_pointer = 32'h2000_0100;
    chan_cfg_s [NUM_CH-1:0] channel_configuration = '0; // per channel settings
    logic [OS_W-1:0] accumulation_exponent = '0; // oversampling exponent
    logic [RATE_W-1:0] rate_compare_field = 11'h010; // timer gap
    logic [CNT_W-1:0] buffer_capacity = 15'h0002, result_amount; // capacity, count
    conv_req_s conv_req; // selected inputs
    logic conv_acquire, conv_start, conv_done, mem_valid, mem_ready, done_event, result_ready_event, end_event, busy;
    logic started_event, stopped_event; // task answers
    logic [RAW_W-1:0] conv_result; // core result
    logic [31:0] mem_addr, mem_data, seed = 32'h29F7364C; // write port, random state
    logic [3:0] mem_strb; // byte enables
    int num_errors = 0, n_tests = 0, n_done, n_rr, n_end, n_st, cycles = 0; // tallies
    logic [15:0] exp_q[$]; // expected halfwords in store order
    adc_channel_sequencer uut (.*);
    conv_mem_model model (.*);
    always #5 clk = ~clk;
    // event tallies and the hang ceiling
    always @(posedge clk)
    begin
        n_done += done_event;
        n_rr += result_ready_event;
        n_end += end_event;
        n_st += started_event;
        if (++cycles > 90000)
        begin
            num_errors++;
            report_and_stop();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string name, input logic [67:0] e, input logic [67:0] g);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one pulse of {stop, sample, start}
    task automatic pulse(input logic [2:0] w);
        @(negedge clk) {stop_task, sample_task, start_task} = w;
        @(negedge clk) {stop_task, sample_task, start_task} = 3'h0;
    endtask
    // random scan set; short acquisition codes keep the run brief
    task automatic rand_cfg(input logic burst);
        for (int c = 0; c < NUM_CH; c++)
        begin
            positive_input_select[4*c+:4] = (rnd() % 3 == 0) ? SEL_NC : 4'(rnd() | 1);
            channel_configuration[c] = {rnd() % 2 == 1, burst, 3'(rnd() % 2)};
        end
        negative_input_select = rnd();
    endtask
    // arm, sample, then compare events and the stored words
    task automatic run(input string name, input int samples, input int reps, input int conv);
        int nen;
        logic [15:0] hi;
        nen = 0;
        for (int c = 0; c < NUM_CH; c++)
            nen += (positive_input_select[4*c+:4] != SEL_NC);
        buffer_capacity = (nen == 0) ? 15'h0002 : 15'(samples * nen * reps);
        pulse(3'h4);
        pulse(3'h1);
        model.words.delete();
        exp_q.delete();
        {n_done, n_rr, n_end, n_st} = '0;
        for (int s = 0; s < samples; s++)
        begin
            pulse(3'h2);
            tick(3);
            while (busy === 1'b1) tick(1);
            repeat (reps) for (int c = 0; c < NUM_CH; c++)
                if (positive_input_select[4*c+:4] != SEL_NC && exp_q.size() < buffer_capacity)
                    exp_q.push_back(16'(signed'({positive_input_select[4*c+:4], channel_configuration[c].diff ?
                        negative_input_select[4*c+:4] : 4'h0, 4'hA})));
        end
        for (int k = 0; k < 20000 && n_end == 0 && exp_q.size() == buffer_capacity; k++) tick(1);
        tick(40);
        check("end event", 32'(exp_q.size() == buffer_capacity), n_end);
        check("result amount", exp_q.size(), result_amount);
        check("started event", 1, n_st);
        check("word count", (exp_q.size() + 1) / 2, model.words.size());
        if (reps == 1) check("done count", samples * nen * conv, n_done);
        if (reps == 1) check("result ready count", samples * nen, n_rr);
        for (int k = 0; k < exp_q.size(); k += 2)
        begin
            hi = (k + 1 < exp_q.size()) ? exp_q[k+1] : 16'h0000;
            check("word", {buffer_pointer + 32'(2 * k), hi == 16'h0000 && k + 1 == exp_q.size() ?
                4'h3 : 4'hF, hi, exp_q[k]}, model.words[k/2]);
        end
        $display("test %s finished, %0d mismatches so far", name, num_errors);
    endtask
    task automatic report_and_stop();
        $display("%0d comparisons, %0d mismatches", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ***********************
    // main sequence
    // ***********************
    initial
    begin
        tick(2);
        rst = 1'b0;
        run("no channel", 1, 1, 1);
        positive_input_select = 32'h0000_00C0;
        run("one shot odd", 3, 1, 1);
        n_rr = n_done;
        pulse(3'h2);
        tick(400);
        check("sample after end", n_rr, n_done);
        repeat (2)
        begin
            rand_cfg(1'b0);
            run("scan", 2, 1, 1);
        end
        rand_cfg(1'b1);
        accumulation_exponent = 4'h2;
        run("burst scan", 1, 1, 4);
        {accumulation_exponent, local_rate_timer} = {4'h0, 1'b1};
        positive_input_select = 32'h0005_0000;
        run("rate timer", 1, 4, 1);
        pulse(3'h4);
        report_and_stop();
    end
endmodule // test_adc_channel_sequencer
bind adc_channel_sequencer seq_props chk (.clk, .rst, .stop_task, .accumulation_exponent, .conv_req,
    .conv_acquire, .conv_start, .conv_done, .mem_valid, .mem_ready, .mem_addr, .mem_data, .done_event,
    .result_ready_event, .stopped_event);
`default_nettype wire
